//--- rtl/sfp_top.v
/*
 * Serial flash command framing and write protection decision.
 * Samples the host's chip select, serial clock and data on clock_in,
 * frames bytes, answers identification and status reads, and hands
 * committed write, program and erase commands to an array engine that
 * reports its own busy level on this clock.
 */
// Notes on behaviour
// - Complement with BP 000 protects all; BP 111 protects nothing.
// - Complement, sector 0, bottom: protect zero up to a shrinking top bound.
// - Complement, sector 0, top: protect from a rising start to the end.
// - Complement, sector 1, bottom: leave 4K to 32K at top open.
// - Complement, sector 1, top: protect from 4K to 32K upward.
// - Erase or program touching any protected byte is dropped entirely.
// - Individual locks count only when the scheme select is one.
// - All individual locks come up set after reset.
// - Chip select falling starts a command; first byte is the opcode.
// - Data is taken on serial clock rising edges, most significant first.
// - Chip select rising ends the command.
// - Reads may end after any bit with no side effect.
// - Write-type commands count only if ended on a byte boundary.
// - While busy, only read status is obeyed.
// - Identification opcodes return maker code and device code; the release opcode returns the device code only.
// - The decoder knows the standard, dual and quad instruction set.
// - With scheme select zero, the status bits define the protected range.
`timescale 1ns/1ps
`include "sfp_defines.vh"
`default_nettype none

module sfp_top #(
    parameter [7:0] MAKER_CODE = 8'h5A,    // Arbitrary value
    parameter [15:0] DEVICE_CODE = 16'hA5C3 // Arbitrary value
) (
    input wire clock_in,
    input wire rst_in,
    input wire chip_select_n_in,
    input wire serial_clock_in,
    input wire serial_data_in,
    output reg serial_data_out,
    output reg serial_data_oe_n_out,
    input wire complement_protect_in,
    input wire sector_granularity_select_in,
    input wire top_bottom_select_in,
    input wire block_protect_bit2_in,
    input wire block_protect_bit1_in,
    input wire block_protect_bit0_in,
    input wire protect_scheme_select_in,
    input wire array_busy_in,
    output reg cmd_commit_out,
    output reg cmd_reject_out,
    output reg cmd_discard_out,
    output reg [7:0] cmd_opcode_out,
    output reg [23:0] cmd_start_out,
    output reg [23:0] cmd_end_out,
    output reg prog_byte_valid_out,
    output reg [7:0] prog_byte_out
);

    // Classify an opcode; anything unlisted is ignored
    function [2:0] op_class;
        input [7:0] op;
        begin
            case (op)
                8'h03, 8'h0B, 8'h4B, 8'h5A, 8'h48, 8'h3D, 8'h3B, 8'hBB,
                8'h6B, 8'hEB: op_class = `SFP_CL_READ;
                `SFP_OP_RDSR1, `SFP_OP_RDSR2, `SFP_OP_RDSR3, `SFP_OP_ID_RELEASE,
                `SFP_OP_ID_MAKER, `SFP_OP_ID_MAKER_DUAL, `SFP_OP_ID_MAKER_QUAD,
                `SFP_OP_ID_STD: op_class = `SFP_CL_REPLY;
                `SFP_OP_PAGE_PROG, `SFP_OP_QUAD_PROG: op_class = `SFP_CL_PROG;
                `SFP_OP_ERASE_4K, `SFP_OP_ERASE_32K,
                `SFP_OP_ERASE_64K: op_class = `SFP_CL_ERASE;
                `SFP_OP_CHIP_ERASE_A, `SFP_OP_CHIP_ERASE_B: op_class = `SFP_CL_CHIP;
                `SFP_OP_LOCK_ONE, `SFP_OP_UNLOCK_ONE: op_class = `SFP_CL_LOCK;
                `SFP_OP_WREN, `SFP_OP_VWREN, `SFP_OP_WRDI, `SFP_OP_WRSR1,
                `SFP_OP_WRSR2, `SFP_OP_WRSR3, `SFP_OP_LOCK_ALL, `SFP_OP_UNLOCK_ALL,
                8'h44, 8'h42, 8'h75, 8'h7A, 8'hB9, 8'h66,
                8'h99: op_class = `SFP_CL_WRITE;
                default: op_class = `SFP_CL_UNKNOWN;
            endcase
        end
    endfunction

    // Span of bytes a program or erase touches, as a low-bit mask
    function [23:0] op_span;
        input [7:0] op;
        begin
            case (op)
                `SFP_OP_ERASE_4K: op_span = `SFP_SECTOR_MASK;
                `SFP_OP_ERASE_32K: op_span = `SFP_HALF_BLOCK_MASK;
                `SFP_OP_ERASE_64K: op_span = `SFP_BLOCK_MASK;
                `SFP_OP_CHIP_ERASE_A, `SFP_OP_CHIP_ERASE_B: op_span = `SFP_ARRAY_TOP;
                default: op_span = `SFP_PAGE_MASK;
            endcase
        end
    endfunction

    // Input pins pass two flops; stage three only feeds edge detection
    reg [2:0] cs_sync_reg;
    reg [2:0] sck_sync_reg;
    reg [1:0] sdi_sync_reg;
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cs_sync_reg <= 3'h7;
            sck_sync_reg <= 3'h0;
            sdi_sync_reg <= 2'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], chip_select_n_in};
            sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_in};
            sdi_sync_reg <= {sdi_sync_reg[0], serial_data_in};
        end
    end

    wire cs_active = ~cs_sync_reg[1];
    wire cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
    wire cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
    wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
    wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
    wire sdi_bit = sdi_sync_reg[1];

    // Frame state
    reg [7:0] shift_reg;
    reg [2:0] bit_cnt_reg;
    reg [3:0] byte_cnt_reg;
    reg [7:0] opcode_reg;
    reg [23:0] addr_reg;
    reg ignore_reg;
    reg parity_reg;
    reg [7:0] tx_reg;

    wire [7:0] byte_now = {shift_reg[6:0], sdi_bit};
    wire byte_done = cs_active & sck_rise & (bit_cnt_reg == 3'h7);
    wire [3:0] byte_cnt_inc = (byte_cnt_reg == 4'hF) ? 4'hF : byte_cnt_reg + 4'h1;
    wire [2:0] cls = op_class(opcode_reg);
    wire [7:0] status_byte = {1'b0, sector_granularity_select_in, top_bottom_select_in,
                              block_protect_bit2_in, block_protect_bit1_in,
                              block_protect_bit0_in, 1'b0, array_busy_in};

    // Reply byte for the byte slot that follows the one just completed
    reg [7:0] reply_next;
    always @* begin
        reply_next = 8'h00;
        case (opcode_reg)
            `SFP_OP_RDSR1: reply_next = status_byte;
            `SFP_OP_ID_STD: begin
                if (byte_cnt_inc == 4'h1) begin
                    reply_next = MAKER_CODE;
                end else if (byte_cnt_inc == 4'h2) begin
                    reply_next = DEVICE_CODE[15:8];
                end else if (byte_cnt_inc == 4'h3) begin
                    reply_next = DEVICE_CODE[7:0];
                end
            end
            `SFP_OP_ID_RELEASE: begin
                if (byte_cnt_inc >= `SFP_ADDR_BYTES) begin
                    reply_next = DEVICE_CODE[7:0];
                end
            end
            `SFP_OP_ID_MAKER, `SFP_OP_ID_MAKER_DUAL, `SFP_OP_ID_MAKER_QUAD: begin
                if (byte_cnt_inc >= `SFP_ADDR_BYTES) begin
                    reply_next = parity_reg ? DEVICE_CODE[7:0] : MAKER_CODE;
                end
            end
            default: reply_next = 8'h00;
        endcase
    end

    // Shift in MSB first on serial clock rise; drive out on its fall
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 4'h0;
            opcode_reg <= 8'h00;
            addr_reg <= 24'h000000;
            ignore_reg <= 1'b0;
            parity_reg <= 1'b0;
            tx_reg <= 8'h00;
            serial_data_out <= 1'b0;
            serial_data_oe_n_out <= 1'b1;
            prog_byte_valid_out <= 1'b0;
            prog_byte_out <= 8'h00;
        end else begin
            prog_byte_valid_out <= 1'b0;
            if (!cs_active) begin
                // Any partial read simply stops here
                bit_cnt_reg <= 3'h0;
                byte_cnt_reg <= 4'h0;
                ignore_reg <= 1'b0;
                parity_reg <= 1'b0;
                serial_data_oe_n_out <= 1'b1;
            end else if (sck_rise) begin
                shift_reg <= byte_now;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    byte_cnt_reg <= byte_cnt_inc;
                    if (byte_cnt_reg == 4'h0) begin
                        opcode_reg <= byte_now;
                        // Busy engine: only the status read gets through
                        ignore_reg <= array_busy_in && (byte_now != `SFP_OP_RDSR1);
                        tx_reg <= (byte_now == `SFP_OP_RDSR1) ? status_byte :
                                  (byte_now == `SFP_OP_ID_STD) ? MAKER_CODE : 8'h00;
                    end else begin
                        tx_reg <= reply_next;
                        if (byte_cnt_inc >= `SFP_ADDR_BYTES) begin
                            parity_reg <= ~parity_reg;
                        end
                        if (byte_cnt_reg < `SFP_ADDR_BYTES) begin
                            addr_reg <= {addr_reg[15:0], byte_now};
                        end else if (cls == `SFP_CL_PROG && !ignore_reg) begin
                            prog_byte_valid_out <= 1'b1;
                            prog_byte_out <= byte_now;
                        end
                    end
                end
            end else if (sck_fall && byte_cnt_reg != 4'h0) begin
                // Reply opcodes drive the data pin from the first falling edge after opcode
                serial_data_out <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
                serial_data_oe_n_out <= ~((cls == `SFP_CL_REPLY) && !ignore_reg);
            end
        end
    end

    // Target range of the framed command, full 24 bits
    wire [23:0] span = op_span(opcode_reg);
    wire [23:0] tgt_start = addr_reg & ~span;
    wire [23:0] tgt_end = addr_reg | span;

    // Unprotected window size under complement; start and end of protected range
    wire [2:0] bp = {block_protect_bit2_in, block_protect_bit1_in, block_protect_bit0_in};
    reg [23:0] open_size;
    reg [23:0] prot_lo;
    reg [23:0] prot_hi;
    always @* begin
        if (sector_granularity_select_in) begin
            // Bit 2 set means 32K, whatever bit 0 says
            if (bp[2]) begin
                open_size = `SFP_FINE_STEP << 3;
            end else begin
                open_size = `SFP_FINE_STEP << (bp[1:0] - 2'h1);
            end
        end else begin
            open_size = `SFP_WIDE_STEP << (bp - 3'h1);
        end
        if (top_bottom_select_in) begin
            prot_lo = open_size;
            prot_hi = `SFP_ARRAY_TOP;
        end else begin
            prot_lo = 24'h000000;
            prot_hi = `SFP_ARRAY_TOP - open_size;
        end
    end

    // Status-bit scheme: compare target against the decoded range
    reg range_hit;
    always @* begin
        if (bp == 3'h0) begin
            range_hit = complement_protect_in;
        end else if (bp == 3'h7) begin
            range_hit = ~complement_protect_in;
        end else if (complement_protect_in) begin
            range_hit = (tgt_start <= prot_hi) && (tgt_end >= prot_lo);
        end else begin
            // Plain table protects exactly what the complement leaves open
            range_hit = (tgt_start < prot_lo) || (tgt_end > prot_hi);
        end
    end

    // Lock map lookup for the addressed block or edge sector
    wire [7:0] blk = addr_reg[23:16];
    wire edge_blk = (blk == `SFP_BLOCK_FIRST) || (blk == `SFP_BLOCK_LAST);
    wire [`SFP_LOCK_AW-1:0] sec_idx = {5'h00, addr_reg[15:12]};
    wire [`SFP_LOCK_AW-1:0] lock_idx = (blk == `SFP_BLOCK_FIRST) ?
        `SFP_LOCK_BOT_BASE + sec_idx : (blk == `SFP_BLOCK_LAST) ?
        `SFP_LOCK_TOP_BASE + sec_idx : {1'b0, blk};
    wire lock_bit;
    wire lock_any;
    wire lock_any_bot;
    wire lock_any_top;
    reg lock_hit;
    always @* begin
        if (cls == `SFP_CL_CHIP) begin
            lock_hit = lock_any;
        end else if (edge_blk && (opcode_reg == `SFP_OP_ERASE_32K ||
                                  opcode_reg == `SFP_OP_ERASE_64K)) begin
            // Covers several sector locks, checked as a group
            lock_hit = (blk == `SFP_BLOCK_FIRST) ? lock_any_bot : lock_any_top;
        end else begin
            lock_hit = lock_bit;
        end
    end

    // Scheme select picks which protection applies
    wire prot_hit = protect_scheme_select_in ? lock_hit : range_hit;

    // Frame end decision, taken on the chip select rise
    wire modifies = (cls == `SFP_CL_PROG) || (cls == `SFP_CL_ERASE) ||
                    (cls == `SFP_CL_CHIP) || (cls == `SFP_CL_LOCK) ||
                    (cls == `SFP_CL_WRITE);
    wire whole_bytes = (bit_cnt_reg == 3'h0) && (byte_cnt_reg != 4'h0);
    wire len_ok = (cls == `SFP_CL_PROG) ? (byte_cnt_reg >= `SFP_PROG_MIN_BYTES) :
                  ((cls == `SFP_CL_ERASE) || (cls == `SFP_CL_LOCK)) ?
                  (byte_cnt_reg == `SFP_ADDR_BYTES) : (byte_cnt_reg == 4'h1);
    wire checked = (cls == `SFP_CL_PROG) || (cls == `SFP_CL_ERASE) || (cls == `SFP_CL_CHIP);
    wire end_live = cs_rise && modifies && !ignore_reg;
    wire framed_ok = whole_bytes && len_ok;
    wire lock_wr = end_live && framed_ok && (cls == `SFP_CL_LOCK);

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_commit_out <= 1'b0;
            cmd_reject_out <= 1'b0;
            cmd_discard_out <= 1'b0;
            cmd_opcode_out <= 8'h00;
            cmd_start_out <= 24'h000000;
            cmd_end_out <= 24'h000000;
        end else begin
            // Misframed write-type commands are dropped
            cmd_discard_out <= end_live && !framed_ok;
            // Protected targets are dropped before the array sees them
            cmd_reject_out <= end_live && framed_ok && checked && prot_hit;
            cmd_commit_out <= end_live && framed_ok && !(checked && prot_hit);
            if (end_live) begin
                cmd_opcode_out <= opcode_reg;
                cmd_start_out <= checked ? tgt_start : addr_reg;
                cmd_end_out <= checked ? tgt_end : addr_reg;
            end
        end
    end

    // Individual lock bits, updated only by committed lock commands
    sfp_lock_mem #(
        .DEPTH(`SFP_LOCK_DEPTH),
        .AW(`SFP_LOCK_AW),
        .BOT_BASE(256),
        .TOP_BASE(272),
        .GROUP(16)
    ) u_lock_mem (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .wr_en_in(lock_wr),
        .wr_addr_in(lock_idx),
        .wr_data_in(opcode_reg == `SFP_OP_LOCK_ONE),
        .set_all_in(end_live && framed_ok && opcode_reg == `SFP_OP_LOCK_ALL),
        .clr_all_in(end_live && framed_ok && opcode_reg == `SFP_OP_UNLOCK_ALL),
        .rd_addr_in(lock_idx),
        .rd_data_out(lock_bit),
        .any_out(lock_any),
        .any_bot_out(lock_any_bot),
        .any_top_out(lock_any_top)
    );

endmodule // sfp_top

`default_nettype wire

//--- rtl/sfp_defines.vh
/*
 * Constants shared by the serial flash protection and framing block:
 * opcodes, address masks, protection steps, lock map layout and the
 * command classes. Assumes a 24-bit byte address into a 16MB array.
 */
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

// Array geometry
`define SFP_ARRAY_TOP 24'hFFFFFF
`define SFP_WIDE_STEP 24'h040000
`define SFP_FINE_STEP 24'h001000
`define SFP_PAGE_MASK 24'h0000FF
`define SFP_SECTOR_MASK 24'h000FFF
`define SFP_HALF_BLOCK_MASK 24'h007FFF
`define SFP_BLOCK_MASK 24'h00FFFF

// Lock map: 256 blocks, then 16 bottom sectors, then 16 top sectors
`define SFP_LOCK_DEPTH 288
`define SFP_LOCK_AW 9
`define SFP_LOCK_BOT_BASE 9'h100
`define SFP_LOCK_TOP_BASE 9'h110
`define SFP_BLOCK_FIRST 8'h00
`define SFP_BLOCK_LAST 8'hFF

// Opcodes
`define SFP_OP_WREN 8'h06
`define SFP_OP_VWREN 8'h50
`define SFP_OP_WRDI 8'h04
`define SFP_OP_RDSR1 8'h05
`define SFP_OP_RDSR2 8'h35
`define SFP_OP_RDSR3 8'h15
`define SFP_OP_WRSR1 8'h01
`define SFP_OP_WRSR2 8'h31
`define SFP_OP_WRSR3 8'h11
`define SFP_OP_ID_RELEASE 8'hAB
`define SFP_OP_ID_MAKER 8'h90
`define SFP_OP_ID_MAKER_DUAL 8'h92
`define SFP_OP_ID_MAKER_QUAD 8'h94
`define SFP_OP_ID_STD 8'h9F
`define SFP_OP_PAGE_PROG 8'h02
`define SFP_OP_QUAD_PROG 8'h32
`define SFP_OP_ERASE_4K 8'h20
`define SFP_OP_ERASE_32K 8'h52
`define SFP_OP_ERASE_64K 8'hD8
`define SFP_OP_CHIP_ERASE_A 8'hC7
`define SFP_OP_CHIP_ERASE_B 8'h60
`define SFP_OP_LOCK_ONE 8'h36
`define SFP_OP_UNLOCK_ONE 8'h39
`define SFP_OP_LOCK_ALL 8'h7E
`define SFP_OP_UNLOCK_ALL 8'h98

// Command classes
`define SFP_CL_UNKNOWN 3'h0
`define SFP_CL_READ 3'h1
`define SFP_CL_REPLY 3'h2
`define SFP_CL_PROG 3'h3
`define SFP_CL_ERASE 3'h4
`define SFP_CL_CHIP 3'h5
`define SFP_CL_LOCK 3'h6
`define SFP_CL_WRITE 3'h7

// Byte counts needed before chip select rises
`define SFP_ADDR_BYTES 4'h4
`define SFP_PROG_MIN_BYTES 4'h5

`endif

//--- rtl/sfp_lock_mem.v
/*
 * Individual block and sector lock bits. One bit per entry, all set at
 * reset, with single-bit writes, whole-map set and clear, a registered
 * read port and registered OR summaries. Runs on the block's clock.
 */
`timescale 1ns/1ps
`default_nettype none

module sfp_lock_mem #(
    parameter DEPTH = 288,
    parameter AW = 9,
    parameter BOT_BASE = 256,
    parameter TOP_BASE = 272,
    parameter GROUP = 16
) (
    input wire clock_in,
    input wire rst_in,
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire wr_data_in,
    input wire set_all_in,
    input wire clr_all_in,
    input wire [AW-1:0] rd_addr_in,
    output reg rd_data_out,
    output reg any_out,
    output reg any_bot_out,
    output reg any_top_out
);

    reg [DEPTH-1:0] lock_reg;

    // Every lock comes up set so the array starts fully protected
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_bit
            always @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    lock_reg[gi] <= 1'b1;
                end else if (set_all_in) begin
                    lock_reg[gi] <= 1'b1;
                end else if (clr_all_in) begin
                    lock_reg[gi] <= 1'b0;
                end else if (wr_en_in && (wr_addr_in == gi)) begin
                    lock_reg[gi] <= wr_data_in;
                end
            end
        end
    endgenerate

    // Read port and summaries are registered so decisions use settled data
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 1'b1;
            any_out <= 1'b1;
            any_bot_out <= 1'b1;
            any_top_out <= 1'b1;
        end else begin
            rd_data_out <= (rd_addr_in < DEPTH) ? lock_reg[rd_addr_in] : 1'b1;
            any_out <= |lock_reg;
            any_bot_out <= |lock_reg[BOT_BASE +: GROUP];
            any_top_out <= |lock_reg[TOP_BASE +: GROUP];
        end
    end

endmodule // sfp_lock_mem

`default_nettype wire

//--- sim/sfp_top_chk.sv
/* Port checker for sfp_top.
   Bound to the design; one clock domain, reset active high. */
`timescale 1ns/1ps
`default_nettype none
module sfp_top_chk (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic chip_select_n_in,
    input wire logic complement_protect_in,
    input wire logic block_protect_bit2_in,
    input wire logic block_protect_bit1_in,
    input wire logic block_protect_bit0_in,
    input wire logic protect_scheme_select_in,
    input wire logic array_busy_in,
    input wire logic serial_data_oe_n_out,
    input wire logic cmd_commit_out,
    input wire logic cmd_reject_out,
    input wire logic cmd_discard_out,
    input wire logic [7:0] cmd_opcode_out,
    input wire logic [23:0] cmd_start_out,
    input wire logic [23:0] cmd_end_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Status table decode and any outcome pulse
    wire logic [2:0] bp = {block_protect_bit2_in, block_protect_bit1_in, block_protect_bit0_in};
    wire logic tbl = !protect_scheme_select_in && complement_protect_in;
    wire logic pulse = cmd_commit_out | cmd_reject_out | cmd_discard_out;
    property p_one_kind; $onehot0({cmd_commit_out, cmd_reject_out, cmd_discard_out}); endproperty
    a_one_kind: assert property (p_one_kind) else $error("two outcomes at once");
    property p_single; pulse |=> !pulse; endproperty
    a_single: assert property (p_single) else $error("outcome pulse too long");
    property p_after_cs; pulse |-> $past(chip_select_n_in) && $past(chip_select_n_in, 2); endproperty
    a_after_cs: assert property (p_after_cs) else $error("outcome before frame end");
    property p_oe_frame; $fell(serial_data_oe_n_out) |-> !$past(chip_select_n_in, 2); endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("reply outside a frame");
    property p_all_shut;
        cmd_commit_out && tbl && bp == 3'h0
            |-> !(cmd_opcode_out inside {8'h02, 8'h32, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60});
    endproperty
    a_all_shut: assert property (p_all_shut) else $error("write into shut array");
    property p_none_shut; cmd_reject_out && tbl |-> bp != 3'h7; endproperty
    a_none_shut: assert property (p_none_shut) else $error("reject with open array");
    property p_range;
        cmd_commit_out && cmd_opcode_out == 8'h20
            |-> cmd_end_out - cmd_start_out == 24'hFFF && cmd_start_out[11:0] == 12'h0;
    endproperty
    a_range: assert property (p_range) else $error("sector range wrong");
    property p_busy; array_busy_in [*8] |-> !pulse; endproperty
    a_busy: assert property (p_busy) else $error("command obeyed while busy");
endmodule // sfp_top_chk

bind sfp_top sfp_top_chk sfp_top_chk_i (.*);
`default_nettype wire

//--- sim/sfp_host_model.sv
/* Serial host model: chip select, 80 ns link clock and data, mode 0.
   Assumes the reply line reads high while the device leaves it. */
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
    output logic cs_n_out,
    output logic sclk_out,
    output logic mosi_out,
    input wire logic miso_in
);
    initial begin
        {cs_n_out, sclk_out, mosi_out} = 3'b100;
    end
    // One frame; the clock stands low outside it, caller picks the bit count
    task automatic xfer(input logic [63:0] tx, input int nb, output logic [63:0] rx);
        rx = '0;
        cs_n_out = 1'b0;
        #40;
        for (int i = 0; i < nb; i++) begin
            mosi_out = tx[63-i];
            #40 sclk_out = 1'b1;
            #40 rx = {rx[62:0], miso_in};
            sclk_out = 1'b0;
        end
        #40 cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // Released line must not look like held data
        #100;
    endtask
endmodule // sfp_host_model
`default_nettype wire

//--- sim/tb_top.sv
/* Self-checking bench for sfp_top with the host model on the link.
   Assumes a 100 MHz block clock; notes queue matches outcome pulses. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [7:0] MK = 8'h5A; // Arbitrary value
    localparam logic [15:0] DV = 16'hA5C3; // Arbitrary value
    localparam logic [50:0] NONE = {2'b11, 49'h0};
    localparam logic [50:0] OK = 51'h0;
    localparam logic [50:0] DIS = {2'b10, 49'h0};
    logic clock_in, rst_in, busy, sch, cmp, sec, tbs, hit;
    logic [2:0] bp, b;
    logic [63:0] rx;
    logic [50:0] seen, e;
    logic [47:0] lh;
    logic [31:0] r;
    logic [31:0] rs = 32'h3A;
    logic [23:0] pt [5];
    int fail_count = 0;
    int checks = 0;
    int nv = 0;
    logic [50:0] q [$];
    wire logic cs_n, sclk, mosi, miso, sdo, oe_n, cmt, rej, dis, pbv;
    wire logic [7:0] opc, pb;
    wire logic [23:0] st, en;
    sfp_top #(.MAKER_CODE(MK), .DEVICE_CODE(DV)) sfp_top_i (.clock_in(clock_in),
        .rst_in(rst_in), .chip_select_n_in(cs_n), .serial_clock_in(sclk),
        .serial_data_in(mosi), .serial_data_out(sdo), .serial_data_oe_n_out(oe_n),
        .complement_protect_in(cmp), .sector_granularity_select_in(sec),
        .top_bottom_select_in(tbs), .block_protect_bit2_in(bp[2]),
        .block_protect_bit1_in(bp[1]), .block_protect_bit0_in(bp[0]),
        .protect_scheme_select_in(sch), .array_busy_in(busy), .cmd_commit_out(cmt),
        .cmd_reject_out(rej), .cmd_discard_out(dis), .cmd_opcode_out(opc),
        .cmd_start_out(st), .cmd_end_out(en), .prog_byte_valid_out(pbv), .prog_byte_out(pb));
    // Reply line is pulled up while not driven
    assign miso = oe_n ? 1'b1 : sdo;
    sfp_host_model sfp_host_model_i (.cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi),
        .miso_in(miso));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    // Protected span {low, high} of the complemented table
    function automatic logic [47:0] prange(input logic g, t, input logic [2:0] k);
        logic [23:0] u;
        u = g ? (24'h001000 << (k[2] ? 3 : k[1:0] - 1)) : (24'h040000 << (k - 1));
        if (k == 3'h0) return {24'h0, 24'hFFFFFF};
        return t ? {u, 24'hFFFFFF} : {24'h0, 24'hFFFFFF - u};
    endfunction
    function automatic logic [50:0] er(input logic [23:0] a, input logic k);
        return {1'b0, k, 1'b1, a & 24'hFFF000, a | 24'h000FFF};
    endfunction
    task automatic check(input logic [63:0] s, x);
        checks++;
        if (s !== x) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic setp(input logic s, c, g, t, input logic [2:0] k, input logic y);
        @(posedge clock_in);
        #1 {sch, cmp, sec, tbs, bp, busy} = {s, c, g, t, k, y};
    endtask
    task automatic frm(input logic [63:0] tx, input int nb, input logic [50:0] x);
        if (x[50:49] != 2'b11) q.push_back(x);
        @(posedge clock_in);
        #1 sfp_host_model_i.xfer(tx, nb, rx);
    endtask
    // Each outcome pulse retires the oldest note
    always @(negedge clock_in) begin
        nv += int'(pbv === 1'b1);
        if ((cmt | rej | dis) === 1'b1) begin
            e = (q.size() != 0) ? q.pop_front() : {51{1'b1}};
            seen = {dis, rej, e[48], e[48] ? {st, en} : 48'h0};
            check(64'(seen), 64'(e));
        end
    end
    // Cuts a hang well past the expected run length
    initial begin
        #900000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        rst_in = 1'b1;
        {sch, cmp, sec, tbs, bp, busy} = {4'b1100, 3'h7, 1'b0};
        repeat (8) @(posedge clock_in);
        #1 rst_in = 1'b0;
        repeat (4) @(posedge clock_in);
        frm({8'h20, 56'h0}, 32, er(24'h0, 1'b1));
        frm({8'h98, 56'h0}, 8, OK);
        frm({8'h20, 24'h123456, 32'h0}, 32, er(24'h123456, 1'b0));
        frm({8'h36, 24'h123456, 32'h0}, 32, OK);
        frm({8'h20, 24'h123456, 32'h0}, 32, er(24'h123456, 1'b1));
        setp(1'b0, 1'b1, 1'b0, 1'b0, 3'h7, 1'b0);
        frm({8'h20, 24'h123456, 32'h0}, 32, er(24'h123456, 1'b0));
        for (int n = 0; n < 16; n++) begin
            r = rnd();
            b = (n == 0) ? 3'h0 : (n == 1) ? 3'h7 : r[4:2];
            setp(1'b0, 1'b1, r[0], r[1], b, 1'b0);
            lh = prange(r[0], r[1], b);
            pt = '{lh[47:24], lh[23:0], lh[47:24] - 24'h1000, lh[23:0] + 24'h1000, r[31:8]};
            foreach (pt[j]) begin
                hit = b != 3'h7 && (pt[j] | 24'hFFF) >= lh[47:24] && (pt[j] & 24'hFFF000) <= lh[23:0];
                frm({8'h20, pt[j], 32'h0}, 32, er(pt[j], hit));
            end
        end
        setp(1'b0, 1'b1, 1'b0, 1'b0, 3'h7, 1'b0);
        frm({8'h02, 24'h4321AB, 8'hC3, 24'h0}, 40, {3'b001, 24'h432100, 24'h4321FF});
        check(64'(pb), 64'hC3);
        frm({8'h02, 24'h4321AB, 32'h0}, 32, DIS);
        check(64'(nv), 64'h1);
        frm({8'h20, 24'h4321AB, 32'h0}, 31, DIS);
        frm({8'h03, 56'h0}, 13, NONE);
        frm({8'h9F, 56'h0}, 32, NONE);
        check(64'(rx[23:0]), 64'({MK, DV}));
        frm({8'hAB, 56'h0}, 40, NONE);
        check(64'(rx[7:0]), 64'(DV[7:0]));
        foreach (pt[j]) begin
            frm({8'h90 + 8'(j % 3) * 8'h02, 56'h0}, 48, NONE);
            check(64'(rx[15:0]), 64'({MK, DV[7:0]}));
        end
        setp(1'b0, 1'b1, 1'b1, 1'b1, 3'h5, 1'b1);
        frm({8'h05, 56'h0}, 16, NONE);
        check(64'(rx[7:0]), 64'h75);
        frm({8'h20, 56'h0}, 32, NONE);
        frm({8'h9F, 56'h0}, 32, NONE);
        check(64'(rx[23:0]), 64'hFFFFFF);
        setp(1'b0, 1'b1, 1'b1, 1'b1, 3'h5, 1'b0);
        repeat (20) @(posedge clock_in);
        check(64'(q.size()), 64'h0);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
